// >>> verilog/ppwe_pkg.sv
package ppwe_pkg;
  localparam int CLK_MHZ = 100;
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * CLK_MHZ;
  localparam int TICK_MS = 5;
  localparam int GLITCH_US = 30;
  localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
  localparam logic [6:0] HWD_RST = 7'h03;
  localparam logic [7:0] PTMO_RST = 8'h0A;
  localparam logic [7:0] DEV_A0 = 8'hA0;
  localparam logic [7:0] DEV_A2 = 8'hA2;
  localparam int MEM_DEPTH = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PF = 5'h02,
    ST_EV = 5'h04,
    ST_SW = 5'h08,
    ST_RA = 5'h10
  } ppwe_state_t;
endpackage

// >>> verilog/ppwe_port.sv
`timescale 1ns/1ps
module ppwe_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic push, pop;
  assign in_ready_out = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid_out = wp_r != rp_r;
  assign out_data_out = mem[rp_r[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end
endmodule // ppwe_fifo

// Behaviour
// RULE_01 - Period in 5 ms steps, zero fetches once
// RULE_02 - Fetch consecutive bytes, length 1 to 32
// RULE_03 - Target device is A0 or A2
// RULE_04 - Start begins periodic fetch, stop halts
// RULE_05 - Completion clears gate; reads served locally
// RULE_06 - Host sets gate before changing range
// RULE_07 - NACK during periodic fetch sets gate
// RULE_08 - Each port has own gate, memory, settings
// RULE_09 - Selected event input edge triggers fetch
// RULE_10 - Event fetch has own range, gate, memory
// RULE_11 - Event success raises interrupt and flag
// RULE_12 - Interrupt pending until host re-arms
// RULE_13 - Event NACK: no gate, no interrupt, armed
// RULE_14 - Event data wins on overlapping reads
// RULE_15 - Scheduled write per port or group, host free
// RULE_16 - Status shows write done or NACKed
// RULE_17 - Scheduled write preempts fetch at byte boundary (only periodic fetch here; event fetch completes first)
// RULE_18 - Watchdog NACKs host on stuck remote access
// RULE_19 - Host watchdog 3 ms default, 1-127 ms
// RULE_20 - Protocol timer returns idle, 10 ms default
// RULE_21 - Held in reset while enable low
// RULE_22 - Ignore false start/stop; filter 30 us glitches
// RULE_23 - Remote access preempts periodic, not event fetch
// RULE_24 - All config and state reset to defaults
module ppwe_port #(parameter int MS_CYC = ppwe_pkg::MS_CYC) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic [7:0] period_in,
  input wire logic [7:0] p_off_in,
  input wire logic [5:0] p_len_in,
  input wire logic p_a2_in,
  input wire logic p_start_in,
  input wire logic p_stop_in,
  input wire logic p_gate_set_in,
  input wire logic [7:0] e_off_in,
  input wire logic [5:0] e_len_in,
  input wire logic e_a2_in,
  input wire logic e_gate_set_in,
  input wire logic [1:0] ev_sel_in,
  input wire logic ev_fall_in,
  input wire logic [2:0] ev_pin_in,
  input wire logic rearm_in,
  input wire logic cfg_wr_in,
  input wire logic [6:0] hwd_ms_in,
  input wire logic [7:0] ptmo_ms_in,
  input wire logic rd_req_in,
  input wire logic rd_a2_in,
  input wire logic [7:0] rd_addr_in,
  output logic rd_valid_out,
  output logic rd_hit_out,
  output logic [7:0] rd_data_out,
  input wire logic wr_clk_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_ready_out,
  input wire logic sw_go_in,
  input wire logic sw_common_in,
  input wire logic sw_a2_in,
  input wire logic [7:0] sw_reg_in,
  output logic [1:0] sw_pstat_out,
  output logic [1:0] sw_cstat_out,
  input wire logic ra_req_in,
  output logic ra_grant_out,
  output logic host_nack_out,
  input wire logic hs_wait_in,
  output logic hs_idle_out,
  output logic ds_req_out,
  output logic ds_wr_out,
  output logic [7:0] ds_dev_out,
  output logic [7:0] ds_reg_out,
  output logic [7:0] ds_wdata_out,
  input wire logic ds_done_in,
  input wire logic ds_nack_in,
  input wire logic [7:0] ds_rdata_in,
  output logic p_gate_out,
  output logic e_gate_out,
  output logic host_int_n_out,
  output logic agg_flag_out
);
  localparam int GL = ppwe_pkg::GLITCH_CYC;
  ppwe_pkg::ppwe_state_t st_r;
  logic [1:0] en_s_r;
  logic srst_r, rst_i;
  logic [7:0] pmem [ppwe_pkg::MEM_DEPTH];
  logic [7:0] emem [ppwe_pkg::MEM_DEPTH];
  logic [16:0] ms_cnt_r;
  logic ms_tick_r, tick5_r;
  logic [2:0] five_r;
  logic running_r, pf_pend_r, ev_pend_r, sw_pend_r, armed_r, irq_r;
  logic [7:0] per_r;
  logic [5:0] idx_r;
  logic [6:0] hwd_lim_r, hwd_cnt_r;
  logic [7:0] ptmo_lim_r, ptmo_cnt_r, dwd_cnt_r;
  logic [2:0] ev_s1_r, ev_s2_r, ev_f_r;
  logic [11:0] gl_cnt_r [3];
  logic ev_prev_r;
  logic [2:0] lk_s_r;
  logic [7:0] wd_s1_r, wd_s2_r;
  logic f_valid, f_pop, f_ready;
  logic [7:0] f_data;
  logic fail, ok, last, pf_ok, pf_ng, ev_ok, ev_ng, sw_end;
  logic ev_sig, ev_trig, hwd_exp, ra_back;

  // RULE_21 enable holds reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      en_s_r <= 2'h0;
      srst_r <= 1'b1;
    end else begin
      en_s_r <= {en_s_r[0], en_in};
      srst_r <= ~en_s_r[1];
    end
  end
  assign rst_i = rst_in | srst_r;

  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] o,
                                  input logic [5:0] n);
    logic [8:0] d;
    d = {1'b0, a} - {1'b0, o};
    in_rng = !d[8] && (d < {3'h0, n});
  endfunction

  // Millisecond and 5 ms timebase
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt_r <= 17'h0;
      ms_tick_r <= 1'b0;
      five_r <= 3'h0;
      tick5_r <= 1'b0;
    end else begin
      ms_tick_r <= ms_cnt_r == 17'(MS_CYC - 1);
      ms_cnt_r <= (ms_cnt_r == 17'(MS_CYC - 1)) ? 17'h0 : ms_cnt_r + 17'h1;
      tick5_r <= ms_tick_r && five_r == 3'(ppwe_pkg::TICK_MS - 1);
      if (ms_tick_r) begin
        five_r <= (five_r == 3'(ppwe_pkg::TICK_MS - 1)) ? 3'h0 : five_r + 3'h1;
      end
    end
  end

  // RULE_24 timeout settings default
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      hwd_lim_r <= ppwe_pkg::HWD_RST;
      ptmo_lim_r <= ppwe_pkg::PTMO_RST;
    end else if (cfg_wr_in) begin
      hwd_lim_r <= hwd_ms_in;
      ptmo_lim_r <= ptmo_ms_in;
    end
  end

  // RULE_22 event input filter
  for (genvar i = 0; i < 3; i++) begin : g_flt
    always_ff @(posedge clock_in or posedge rst_i) begin
      if (rst_i) begin
        ev_s1_r[i] <= 1'b0;
        ev_s2_r[i] <= 1'b0;
        ev_f_r[i] <= 1'b0;
        gl_cnt_r[i] <= 12'h0;
      end else begin
        ev_s1_r[i] <= ev_pin_in[i];
        ev_s2_r[i] <= ev_s1_r[i];
        if (ev_s2_r[i] == ev_f_r[i]) begin
          gl_cnt_r[i] <= 12'h0;
        end else if (gl_cnt_r[i] == 12'(GL - 1)) begin
          ev_f_r[i] <= ev_s2_r[i];
          gl_cnt_r[i] <= 12'h0;
        end else begin
          gl_cnt_r[i] <= gl_cnt_r[i] + 12'h1;
        end
      end
    end
  end

  // RULE_09 selected edge detect
  assign ev_sig = (ev_sel_in == 2'h0) ? ev_f_r[0] :
                  (ev_sel_in == 2'h1) ? ev_f_r[1] : ev_f_r[2];
  assign ev_trig = ev_fall_in ? (ev_prev_r && !ev_sig) : (!ev_prev_r && ev_sig);

  // Write bytes arrive on the slow link clock; the link clock is only sampled
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      lk_s_r <= 3'h0;
      wd_s1_r <= 8'h0;
      wd_s2_r <= 8'h0;
    end else begin
      lk_s_r <= {lk_s_r[1:0], wr_clk_in};
      wd_s1_r <= wr_data_in;
      wd_s2_r <= wd_s1_r;
    end
  end

  ppwe_fifo #(.WIDTH(ppwe_pkg::FIFO_WIDTH), .DEPTH(ppwe_pkg::FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_i),
    .in_valid_in(lk_s_r[1] && !lk_s_r[2]),
    .in_ready_out(f_ready),
    .in_data_in(wd_s2_r),
    .out_valid_out(f_valid),
    .out_ready_in(f_pop),
    .out_data_out(f_data)
  );

  // A zero limit turns the port watchdog off instead of failing at once
  assign fail = ds_req_out && (ds_nack_in || (hwd_lim_r != 7'h0 &&
                dwd_cnt_r == {1'b0, hwd_lim_r}));
  assign ok = ds_req_out && ds_done_in && !fail;
  assign last = ({1'b0, idx_r} + 7'h1) >= {1'b0, (st_r == ppwe_pkg::ST_EV) ?
                e_len_in : p_len_in};
  assign pf_ok = st_r == ppwe_pkg::ST_PF && ok && last;
  assign pf_ng = st_r == ppwe_pkg::ST_PF && fail;
  assign ev_ok = st_r == ppwe_pkg::ST_EV && ok && last;
  assign ev_ng = st_r == ppwe_pkg::ST_EV && fail;
  assign sw_end = st_r == ppwe_pkg::ST_SW && (fail || (ok && !f_valid));
  assign f_pop = f_valid && ((st_r == ppwe_pkg::ST_IDLE && !ra_req_in &&
                 sw_pend_r) || (st_r == ppwe_pkg::ST_SW && ok));
  assign hwd_exp = hwd_lim_r != 7'h0 && hwd_cnt_r == hwd_lim_r;
  assign ra_back = st_r == ppwe_pkg::ST_PF && ok && !last && ra_req_in;

  // RULE_01 period and one-time fetch
  // RULE_04 start and stop
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      running_r <= 1'b0;
      pf_pend_r <= 1'b0;
      per_r <= 8'h0;
    end else if (p_start_in) begin
      running_r <= period_in != 8'h0;
      pf_pend_r <= 1'b1;
      per_r <= period_in;
    end else if (p_stop_in) begin
      running_r <= 1'b0;
      pf_pend_r <= 1'b0;
    end else begin
      // Pending is consumed on the cycle idle picks the fetch
      if (st_r == ppwe_pkg::ST_IDLE && !ra_req_in && !ev_pend_r &&
          !(sw_pend_r && f_valid)) pf_pend_r <= 1'b0;
      // RULE_23 restart after remote access
      if (ra_back) pf_pend_r <= 1'b1;
      if (running_r && tick5_r) begin
        if (per_r <= 8'h1) begin
          pf_pend_r <= 1'b1;
          per_r <= period_in;
        end else begin
          per_r <= per_r - 8'h1;
        end
      end
    end
  end

  // RULE_12 arm, pending irq, re-arm
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      ev_prev_r <= 1'b0;
      ev_pend_r <= 1'b0;
      armed_r <= 1'b1;
      irq_r <= 1'b0;
      sw_pend_r <= 1'b0;
    end else begin
      ev_prev_r <= ev_sig;
      if (armed_r && ev_trig) ev_pend_r <= 1'b1;
      // RULE_13 nack stays armed
      if (ev_ok || ev_ng) ev_pend_r <= 1'b0;
      if (rearm_in) begin
        armed_r <= 1'b1;
        irq_r <= 1'b0;
      end
      // RULE_11 interrupt on success
      if (ev_ok) begin
        armed_r <= 1'b0;
        irq_r <= 1'b1;
      end
      // RULE_15 host released after go
      if (sw_go_in) sw_pend_r <= 1'b1;
      else if (sw_end) sw_pend_r <= 1'b0;
    end
  end

  // Downstream engine
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ppwe_pkg::ST_IDLE;
      idx_r <= 6'h0;
      ds_req_out <= 1'b0;
      ds_wr_out <= 1'b0;
      ds_dev_out <= ppwe_pkg::DEV_A0;
      ds_reg_out <= 8'h0;
      ds_wdata_out <= 8'h0;
      ra_grant_out <= 1'b0;
      host_nack_out <= 1'b0;
    end else begin
      host_nack_out <= 1'b0;
      unique case (st_r)
        ppwe_pkg::ST_IDLE: begin
          idx_r <= 6'h0;
          if (ra_req_in) begin
            st_r <= ppwe_pkg::ST_RA;
            ra_grant_out <= 1'b1;
          end else if (sw_pend_r && f_valid) begin
            st_r <= ppwe_pkg::ST_SW;
            ds_req_out <= 1'b1;
            ds_wr_out <= 1'b1;
            ds_dev_out <= sw_a2_in ? ppwe_pkg::DEV_A2 : ppwe_pkg::DEV_A0;
            ds_reg_out <= sw_reg_in;
            ds_wdata_out <= f_data;
          end else if (ev_pend_r) begin
            // RULE_10 event range and device
            st_r <= ppwe_pkg::ST_EV;
            ds_req_out <= 1'b1;
            ds_wr_out <= 1'b0;
            ds_dev_out <= e_a2_in ? ppwe_pkg::DEV_A2 : ppwe_pkg::DEV_A0;
            ds_reg_out <= e_off_in;
          end else if (pf_pend_r) begin
            // RULE_03 device select
            st_r <= ppwe_pkg::ST_PF;
            ds_req_out <= 1'b1;
            ds_wr_out <= 1'b0;
            ds_dev_out <= p_a2_in ? ppwe_pkg::DEV_A2 : ppwe_pkg::DEV_A0;
            ds_reg_out <= p_off_in;
          end
        end
        ppwe_pkg::ST_PF, ppwe_pkg::ST_EV: begin
          // RULE_02 consecutive bytes
          // RULE_17 preempt at byte boundary
          if (fail || (ok && (last || (st_r == ppwe_pkg::ST_PF &&
              (ra_req_in || sw_pend_r))))) begin
            st_r <= ppwe_pkg::ST_IDLE;
            ds_req_out <= 1'b0;
          end else if (ok) begin
            idx_r <= idx_r + 6'h1;
            ds_reg_out <= ds_reg_out + 8'h1;
          end
        end
        ppwe_pkg::ST_SW: begin
          if (sw_end) begin
            st_r <= ppwe_pkg::ST_IDLE;
            ds_req_out <= 1'b0;
          end else if (ok) begin
            ds_reg_out <= ds_reg_out + 8'h1;
            ds_wdata_out <= f_data;
          end
        end
        ppwe_pkg::ST_RA: begin
          // RULE_18 watchdog ends remote access
          if (!ra_req_in || hwd_exp) begin
            st_r <= ppwe_pkg::ST_IDLE;
            ra_grant_out <= 1'b0;
            host_nack_out <= hwd_exp;
          end
        end
        default: begin
          st_r <= ppwe_pkg::ST_IDLE;
          ds_req_out <= 1'b0;
          ra_grant_out <= 1'b0;
        end
      endcase
    end
  end

  // RULE_19 host and port watchdogs
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      hwd_cnt_r <= 7'h0;
      dwd_cnt_r <= 8'h0;
    end else begin
      if (st_r != ppwe_pkg::ST_RA || hwd_lim_r == 7'h0) hwd_cnt_r <= 7'h0;
      else if (ms_tick_r && !hwd_exp) hwd_cnt_r <= hwd_cnt_r + 7'h1;
      // Port timer restarts per byte; zero limit leaves it off
      if (!ds_req_out || ds_done_in || hwd_lim_r == 7'h0) dwd_cnt_r <= 8'h0;
      else if (ms_tick_r) dwd_cnt_r <= dwd_cnt_r + 8'h1;
    end
  end

  // RULE_20 protocol timeout
  // RULE_22 stray start/stop never arms this timer alone
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      ptmo_cnt_r <= 8'h0;
      hs_idle_out <= 1'b0;
    end else begin
      hs_idle_out <= hs_wait_in && ms_tick_r && ptmo_cnt_r + 8'h1 >= ptmo_lim_r;
      if (!hs_wait_in || hs_idle_out) ptmo_cnt_r <= 8'h0;
      else if (ms_tick_r) ptmo_cnt_r <= ptmo_cnt_r + 8'h1;
    end
  end

  // RULE_08 per-port memories
  always_ff @(posedge clock_in) begin
    if (st_r == ppwe_pkg::ST_PF && ok) pmem[idx_r[4:0]] <= ds_rdata_in;
    if (st_r == ppwe_pkg::ST_EV && ok) emem[idx_r[4:0]] <= ds_rdata_in;
  end

  // RULE_05 gate clear on completion
  // RULE_07 nack sets gate
  // RULE_06 host sets gate
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      p_gate_out <= 1'b1;
      e_gate_out <= 1'b1;
    end else begin
      if (pf_ok) p_gate_out <= 1'b0;
      else if (pf_ng || p_gate_set_in) p_gate_out <= 1'b1;
      if (ev_ok) e_gate_out <= 1'b0;
      else if (e_gate_set_in) e_gate_out <= 1'b1;
    end
  end

  // RULE_16 write status
  // RULE_14 event data first
  always_ff @(posedge clock_in or posedge rst_i) begin
    if (rst_i) begin
      sw_pstat_out <= 2'h0;
      sw_cstat_out <= 2'h0;
      rd_valid_out <= 1'b0;
      rd_hit_out <= 1'b0;
      rd_data_out <= 8'h0;
      host_int_n_out <= 1'b1;
      agg_flag_out <= 1'b0;
      wr_ready_out <= 1'b0;
    end else begin
      wr_ready_out <= f_ready;
      host_int_n_out <= !(irq_r || ev_ok);
      agg_flag_out <= irq_r || ev_ok;
      if (sw_end && !sw_common_in) sw_pstat_out <= {fail, !fail};
      if (sw_end && sw_common_in) sw_cstat_out <= {fail, !fail};
      rd_valid_out <= rd_req_in;
      rd_hit_out <= 1'b0;
      rd_data_out <= 8'h0;
      if (rd_req_in && !e_gate_out && rd_a2_in == e_a2_in &&
          in_rng(rd_addr_in, e_off_in, e_len_in)) begin
        rd_hit_out <= 1'b1;
        rd_data_out <= emem[5'(rd_addr_in - e_off_in)];
      end else if (rd_req_in && !p_gate_out && rd_a2_in == p_a2_in &&
                   in_rng(rd_addr_in, p_off_in, p_len_in)) begin
        rd_hit_out <= 1'b1;
        rd_data_out <= pmem[5'(rd_addr_in - p_off_in)];
      end
    end
  end

  chk_gate_clear_done: assert property ( // RULE_05
    @(posedge clock_in) disable iff (rst_i) pf_ok |=> !p_gate_out)
    else $error("gate not cleared");
  chk_nack_gate_set: assert property ( // RULE_07
    @(posedge clock_in) disable iff (rst_i) pf_ng |=> p_gate_out)
    else $error("gate not set on nack");
  chk_irq_on_event: assert property ( // RULE_11
    @(posedge clock_in) disable iff (rst_i)
    ev_ok |=> !host_int_n_out && agg_flag_out && !armed_r)
    else $error("no interrupt");
  chk_irq_stays_pending: assert property ( // RULE_12
    @(posedge clock_in) disable iff (rst_i) irq_r && !rearm_in |=> irq_r)
    else $error("irq dropped");
  chk_event_nack_quiet: assert property ( // RULE_13
    @(posedge clock_in) disable iff (rst_i)
    ev_ng && !rearm_in && !e_gate_set_in |=> $stable(irq_r) && armed_r &&
    $stable(e_gate_out)) else $error("event nack side effect");
  chk_write_preempts: assert property ( // RULE_17
    @(posedge clock_in) disable iff (rst_i)
    st_r == ppwe_pkg::ST_PF && ok && sw_pend_r && f_valid |=>
    st_r == ppwe_pkg::ST_IDLE ##1 st_r != ppwe_pkg::ST_PF)
    else $error("fetch not preempted");
  chk_watchdog_nack: assert property ( // RULE_18
    @(posedge clock_in) disable iff (rst_i)
    st_r == ppwe_pkg::ST_RA && hwd_exp |=> host_nack_out && !ra_grant_out)
    else $error("watchdog missed");
  chk_filter_glitch: assert property ( // RULE_22
    @(posedge clock_in) disable iff (rst_i)
    $changed(ev_f_r[2]) |-> $past(gl_cnt_r[2]) == 12'(GL - 1))
    else $error("glitch passed");
endmodule // ppwe_port

// >>> verif/ppwe_ds_model.sv
`timescale 1ns/1ps
module ppwe_ds_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [7:0] dev_in,
  input wire logic [7:0] reg_in,
  input wire logic [7:0] wdata_in,
  input wire logic [3:0] dly_in,
  input wire logic nack_en_in,
  input wire logic [7:0] salt_in,
  output logic done_out,
  output logic nack_out,
  output logic [7:0] rdata_out,
  output logic [7:0] wcnt_out,
  output logic [7:0] wlast_out
);
  logic [3:0] cnt_r;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      done_out <= 1'h0;
      nack_out <= 1'h0;
      rdata_out <= 8'h00;
      wcnt_out <= 8'h00;
      wlast_out <= 8'h00;
    end else begin
      done_out <= 1'h0;
      nack_out <= 1'h0;
      // Data only valid with done; toggles otherwise so stale reads show
      rdata_out <= ~rdata_out;
      if (req_in && !done_out && !nack_out) begin
        if (cnt_r == dly_in) begin
          cnt_r <= 4'h0;
          if (nack_en_in) begin
            nack_out <= 1'h1;
          end else begin
            done_out <= 1'h1;
            rdata_out <= reg_in ^ salt_in ^ {dev_in[1], 7'h00};
            if (wr_in) begin
              wcnt_out <= wcnt_out + 8'h01;
              wlast_out <= wdata_in;
            end
          end
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end
endmodule // ppwe_ds_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = '0, rst = '1, en = '1, p_a2 = '0, p_start = '0, p_stop = '0;
  logic p_gs = '0, e_a2 = '0, e_gs = '0, ev_fall = '0, rearm = '0;
  logic cfg_wr = '0, rd_req = '0, rd_a2 = '0, wr_clk = '0, sw_go = '0;
  logic sw_com = '0, ra_req = '0, hs_wait = '0, nack_en = '0;
  logic [7:0] period = '0, p_off = '0, e_off = '0, rd_addr = '0;
  logic [7:0] wr_data = '0, salt = '0, ptmo = '0;
  logic [5:0] p_len = '0, e_len = '0;
  logic [6:0] hwd = '0;
  logic [3:0] dly = 4'h2;
  logic [2:0] ev_pin = '0;
  logic [1:0] ev_sel = 2'h2;
  logic rd_valid, rd_hit, wr_ready, ra_grant, host_nack, hs_idle, ds_req;
  logic ds_wr, ds_done, ds_nack, p_gate, e_gate, int_n, agg;
  logic [7:0] rd_data, ds_dev, ds_reg, ds_wdata, ds_rdata, wcnt, wlast;
  logic [1:0] pstat, cstat;
  int err_count = 0, comparisons = 0, cyc = 0, t;
  always #5 clk = ~clk;
  ppwe_port #(.MS_CYC(100)) dut (
    .clock_in(clk), .rst_in(rst), .en_in(en), .period_in(period),
    .p_off_in(p_off), .p_len_in(p_len), .p_a2_in(p_a2),
    .p_start_in(p_start), .p_stop_in(p_stop), .p_gate_set_in(p_gs),
    .e_off_in(e_off), .e_len_in(e_len), .e_a2_in(e_a2),
    .e_gate_set_in(e_gs), .ev_sel_in(ev_sel), .ev_fall_in(ev_fall),
    .ev_pin_in(ev_pin), .rearm_in(rearm), .cfg_wr_in(cfg_wr),
    .hwd_ms_in(hwd), .ptmo_ms_in(ptmo), .rd_req_in(rd_req),
    .rd_a2_in(rd_a2), .rd_addr_in(rd_addr), .rd_valid_out(rd_valid),
    .rd_hit_out(rd_hit), .rd_data_out(rd_data), .wr_clk_in(wr_clk),
    .wr_data_in(wr_data), .wr_ready_out(wr_ready), .sw_go_in(sw_go),
    .sw_common_in(sw_com), .sw_a2_in(p_a2), .sw_reg_in(p_off),
    .sw_pstat_out(pstat), .sw_cstat_out(cstat), .ra_req_in(ra_req),
    .ra_grant_out(ra_grant), .host_nack_out(host_nack),
    .hs_wait_in(hs_wait), .hs_idle_out(hs_idle), .ds_req_out(ds_req),
    .ds_wr_out(ds_wr), .ds_dev_out(ds_dev), .ds_reg_out(ds_reg),
    .ds_wdata_out(ds_wdata), .ds_done_in(ds_done), .ds_nack_in(ds_nack),
    .ds_rdata_in(ds_rdata), .p_gate_out(p_gate), .e_gate_out(e_gate),
    .host_int_n_out(int_n), .agg_flag_out(agg));
  ppwe_ds_model far (
    .clock_in(clk), .rst_in(rst), .req_in(ds_req), .wr_in(ds_wr),
    .dev_in(ds_dev), .reg_in(ds_reg), .wdata_in(ds_wdata), .dly_in(dly),
    .nack_en_in(nack_en), .salt_in(salt), .done_out(ds_done),
    .nack_out(ds_nack), .rdata_out(ds_rdata), .wcnt_out(wcnt),
    .wlast_out(wlast));
  task give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [7:0] xd(logic a, logic [7:0] r, logic [7:0] s);
    return r ^ s ^ {a, 7'h00};
  endfunction
  function automatic logic pick(input int k);
    case (k)
      0: return p_gate;
      1: return e_gate;
      2: return host_nack;
      3: return hs_idle;
      4: return pstat != 2'h0;
      5: return cstat != 2'h0;
      7: return ds_req;
      default: return ra_grant;
    endcase
  endfunction
  // Bounded wait, sampled mid-cycle; t holds the cycles spent
  task wt(input int k, input logic v, input int n);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (pick(k) !== v && t < n);
    if (pick(k) !== v) chk($sformatf("wait %0d", k), 8'h01, 8'h00);
  endtask
  task idle(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (ds_req !== 1'h0) c++;
    end
    chk("ds_busy", 8'h00, {7'h00, c != 0});
  endtask
  task rd(input logic a, input logic [7:0] ad, input logic h,
          input logic [7:0] d);
    tick(1);
    rd_req <= 1'h1;
    rd_a2 <= a;
    rd_addr <= ad;
    tick(1);
    rd_req <= 1'h0;
    @(negedge clk);
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("rd_hit", {7'h00, h}, {7'h00, rd_hit});
    chk("rd_data", h ? d : 8'h00, rd_data);
  endtask
  // One link byte: 160 ns frame, clock idle low between frames
  task push(input logic [7:0] b);
    tick(1);
    wr_data <= b;
    tick(7);
    wr_clk <= 1'h1;
    tick(8);
    wr_clk <= 1'h0;
    wr_data <= ~b;
  endtask
  initial begin
    tick(20);
    rst <= 1'h0;
    tick(5);
    @(negedge clk);
    chk("p_gate", 8'h01, {7'h00, p_gate});
    chk("int_n", 8'h01, {7'h00, int_n});
    chk("ds_dev", 8'hA0, ds_dev);
    tick(1);
    p_off <= 8'h10;
    p_len <= 6'h04;
    p_a2 <= 1'h1;
    p_start <= 1'h1;
    tick(1);
    p_start <= 1'h0;
    wt(0, 1'h0, 2000);
    for (int i = 0; i < 4; i++) rd(1'h1, 8'h10 + i[7:0], 1'h1,
      xd(1'h1, 8'h10 + i[7:0], 8'h00));
    rd(1'h1, 8'h14, 1'h0, 8'h00);
    rd(1'h0, 8'h10, 1'h0, 8'h00);
    idle(700);
    tick(1);
    p_gs <= 1'h1;
    tick(1);
    p_gs <= 1'h0;
    rd(1'h1, 8'h10, 1'h0, 8'h00);
    tick(1);
    period <= 8'h01;
    p_start <= 1'h1;
    tick(1);
    p_start <= 1'h0;
    wt(0, 1'h0, 300);
    nack_en <= 1'h1;
    wt(0, 1'h1, 1000);
    wt(7, 1'h1, 600);
    chk("pf_period", 8'h01, {7'h00, t >= 490 && t <= 500});
    tick(1);
    p_stop <= 1'h1;
    tick(1);
    p_stop <= 1'h0;
    wt(7, 1'h0, 20);
    nack_en <= 1'h0;
    idle(1200);
    tick(1);
    e_off <= 8'h10;
    e_len <= 6'h20;
    e_a2 <= 1'h1;
    salt <= 8'h5A;
    ev_pin[2] <= 1'h1;
    tick(1000);
    ev_pin[2] <= 1'h0;
    idle(4000);
    tick(1);
    ev_pin[2] <= 1'h1;
    wt(1, 1'h0, 5000);
    chk("int_n", 8'h00, {7'h00, int_n});
    chk("agg", 8'h01, {7'h00, agg});
    rd(1'h1, 8'h2F, 1'h1, xd(1'h1, 8'h2F, 8'h5A));
    rd(1'h1, 8'h30, 1'h0, 8'h00);
    tick(1);
    salt <= 8'h00;
    period <= 8'h00;
    p_start <= 1'h1;
    tick(1);
    p_start <= 1'h0;
    wt(0, 1'h0, 500);
    rd(1'h1, 8'h11, 1'h1, xd(1'h1, 8'h11, 8'h5A));
    tick(1);
    ev_pin[2] <= 1'h0;
    tick(3500);
    ev_pin[2] <= 1'h1;
    idle(4000);
    chk("int_n", 8'h00, {7'h00, int_n});
    tick(1);
    rearm <= 1'h1;
    tick(1);
    rearm <= 1'h0;
    tick(3);
    @(negedge clk);
    chk("int_n", 8'h01, {7'h00, int_n});
    tick(1);
    e_gs <= 1'h1;
    ev_fall <= 1'h1;
    nack_en <= 1'h1;
    tick(1);
    e_gs <= 1'h0;
    ev_pin[2] <= 1'h0;
    tick(4000);
    @(negedge clk);
    chk("e_gate", 8'h01, {7'h00, e_gate});
    chk("int_n", 8'h01, {7'h00, int_n});
    tick(1);
    nack_en <= 1'h0;
    ev_pin[2] <= 1'h1;
    tick(3500);
    ev_pin[2] <= 1'h0;
    wt(1, 1'h0, 5000);
    chk("int_n", 8'h00, {7'h00, int_n});
    dly <= 4'h6;
    for (int i = 0; i < 16; i++) push(8'hC0 + i[7:0]);
    tick(4);
    @(negedge clk);
    chk("wr_ready", 8'h00, {7'h00, wr_ready});
    push(8'hEE);
    p_start <= 1'h1;
    tick(1);
    p_start <= 1'h0;
    tick(2);
    sw_go <= 1'h1;
    tick(1);
    sw_go <= 1'h0;
    wt(4, 1'h1, 3000);
    chk("pstat", 8'h01, {6'h00, pstat});
    chk("wcnt", 8'h10, wcnt);
    chk("wlast", 8'hCF, wlast);
    chk("wr_ready", 8'h01, {7'h00, wr_ready});
    nack_en <= 1'h1;
    push(8'h55);
    sw_com <= 1'h1;
    sw_go <= 1'h1;
    tick(1);
    sw_go <= 1'h0;
    wt(5, 1'h1, 3000);
    chk("cstat", 8'h02, {6'h00, cstat});
    tick(1);
    nack_en <= 1'h0;
    hwd <= 7'h02;
    ptmo <= 8'h03;
    cfg_wr <= 1'h1;
    tick(1);
    cfg_wr <= 1'h0;
    ra_req <= 1'h1;
    wt(6, 1'h1, 5);
    wt(2, 1'h1, 400);
    // Millisecond base runs free, so a 2 ms limit ends in 1 to 2 ms
    chk("hwd_t", 8'h01, {7'h00, t >= 95 && t <= 205});
    tick(1);
    ra_req <= 1'h0;
    hs_wait <= 1'h1;
    wt(3, 1'h1, 500);
    chk("ptmo_t", 8'h01, {7'h00, t >= 195 && t <= 305});
    tick(1);
    hs_wait <= 1'h0;
    en <= 1'h0;
    tick(5);
    @(negedge clk);
    chk("p_gate", 8'h01, {7'h00, p_gate});
    chk("e_gate", 8'h01, {7'h00, e_gate});
    chk("int_n", 8'h01, {7'h00, int_n});
    give_verdict;
  end
endmodule // tb
